// ==== hdl/csfm_map.vh ====
`ifndef CSFM_MAP_VH
`define CSFM_MAP_VH

// ***************************************************
// Register offsets
// ***************************************************
`define CSFM_OFS_BUCK_CFG 8'h09
`define CSFM_OFS_OPT_LIMIT 8'h0A
`define CSFM_OFS_STATUS_ONE 8'h0B
`define CSFM_OFS_STATUS_TWO 8'h0C
`define CSFM_OFS_THERM_STATUS 8'h0D
`define CSFM_OFS_FAULT_STATUS 8'h0E
`define CSFM_OFS_FLAGS_ONE 8'h0F
`define CSFM_OFS_FLAGS_TWO 8'h10
`define CSFM_OFS_FAULT_FLAGS 8'h11
`define CSFM_OFS_MASK_ONE 8'h12
`define CSFM_OFS_MASK_TWO 8'h13
`define CSFM_OFS_FAULT_MASK 8'h14

// ***************************************************
// Reset values and writable bits
// ***************************************************
`define CSFM_RST_BUCK_CFG 8'hF6
`define CSFM_RST_ZERO 8'h00
`define CSFM_WMASK_BUCK_CFG 8'hFF
`define CSFM_WMASK_MASK_ONE 8'hF9
`define CSFM_WMASK_MASK_TWO 8'h97
`define CSFM_WMASK_FAULT_MASK 8'hF9

// ***************************************************
// Field layout
// ***************************************************
`define CSFM_BUCK_VOLT_MSB 3
`define CSFM_BUCK_VOLT_MAX 4'hA
`define CSFM_ADC_DONE_BLOCK_BIT 7
`define CSFM_FLAG_MIN_SYS_BIT 0
`define CSFM_FLAG_SRC_GOOD_BIT 7

// ***************************************************
// Synchroniser vector layout
// ***************************************************
`define CSFM_SYNC_WIDTH 31
`define CSFM_SY_LOOPS_LSB 0
`define CSFM_SY_LOOPS_MSB 3
`define CSFM_SY_PHASE_LSB 4
`define CSFM_SY_PHASE_MSB 6
`define CSFM_SY_GOOD 7
`define CSFM_SY_SRC_LSB 8
`define CSFM_SY_SRC_MSB 10
`define CSFM_SY_OPT_LSB 11
`define CSFM_SY_OPT_MSB 12
`define CSFM_SY_MINSYS 13
`define CSFM_SY_TS_LSB 14
`define CSFM_SY_TS_MSB 16
`define CSFM_SY_FAULT_LSB 17
`define CSFM_SY_FAULT_MSB 20
`define CSFM_SY_BUCK_FAULT 21
`define CSFM_SY_LIMIT_LSB 22
`define CSFM_SY_LIMIT_MSB 26
`define CSFM_SY_ADC_DONE 27
`define CSFM_SY_ONE_SHOT 28
`define CSFM_SY_SCL 29
`define CSFM_SY_SDA 30
`define CSFM_SYNC_IDLE 31'h60000000

// ***************************************************
// Timing
// ***************************************************
`define CSFM_CLK_PERIOD_NS 10
`define CSFM_INT_PULSE_NS 1000
`define CSFM_INT_PULSE_CYCLES (`CSFM_INT_PULSE_NS / `CSFM_CLK_PERIOD_NS)
`define CSFM_DEV_ADDR 7'h50

`endif

// ==== hdl/csfm_flag_bank.v ====
// Function
// - Buck voltage code clamps above Ah
// - Optimizer applied limit readable, five bits
// - Reserved bits read zero, ignore writes
// - Live loop and watchdog status bits
// - Three-bit charge phase status field
// - Source good bit follows qualification
// - Three-bit input source type field
// - Two-bit optimizer state field
// - Minimum system regulation status bit
// - Thermistor zone field, upper bits zero
// - Live fault status bits
// - Loop and watchdog rising edges set flags
// - Charge phase change sets flag
// - Source good toggle sets flag
// - Source and zone changes set flags
// - Optimizer state change sets flag
// - Min system entry or exit sets flag
// - Fault entries set fault flags
// - Buck fault sets its own flag
// - Mask zero passes, one blocks pulse
// - Conversion mask only in one-shot mode
// - Charge phase mask gates its pulse
// - Over-voltage mask gates its pulse
`timescale 1ns/1ps
`include "csfm_map.vh"

module csfm_flag_bank
#(
  parameter [6:0] DEV_ADDR = `CSFM_DEV_ADDR,
  parameter INT_PULSE_CYCLES = `CSFM_INT_PULSE_CYCLES
)
(
  input wire CLK_I,
  input wire RST_I,
  input wire SCL_I,
  input wire SDA_I,
  output wire SDA_O,
  output wire SDA_OE_O,
  output wire INT_O,
  output reg INT_OE_O,
  input wire INPUT_CURRENT_LOOP_ACTIVE_I,
  input wire INPUT_VOLTAGE_LOOP_ACTIVE_I,
  input wire THERMAL_LOOP_ACTIVE_I,
  input wire WATCHDOG_EXPIRED_STATE_I,
  input wire [2:0] CHARGE_PHASE_I,
  input wire SOURCE_GOOD_STATE_I,
  input wire [2:0] INPUT_SOURCE_TYPE_I,
  input wire [1:0] OPTIMIZER_STATE_I,
  input wire MIN_SYSTEM_REGULATING_I,
  input wire [2:0] THERMISTOR_ZONE_I,
  input wire INPUT_OVERVOLTAGE_STATE_I,
  input wire DIE_SHUTDOWN_STATE_I,
  input wire BATTERY_OVERVOLTAGE_STATE_I,
  input wire SAFETY_TIMER_EXPIRED_STATE_I,
  input wire BUCK_OUTPUT_FAULT_I,
  input wire [4:0] OPTIMIZER_APPLIED_LIMIT_I,
  input wire CONVERSION_DONE_I,
  input wire CONVERSION_ONE_SHOT_I,
  output reg [3:0] BUCK_OUTPUT_VOLTAGE_SETTING_O
);

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  // Multi-bit fields are synced bit by bit; a skewed change can raise
  // one extra change flag, which is harmless for a sticky event.
  wire [`CSFM_SYNC_WIDTH-1:0] raw_in;
  reg [`CSFM_SYNC_WIDTH-1:0] sync_a;
  reg [`CSFM_SYNC_WIDTH-1:0] sync_b;
  reg [`CSFM_SYNC_WIDTH-1:0] sync_c;

  assign raw_in = {SDA_I, SCL_I, CONVERSION_ONE_SHOT_I, CONVERSION_DONE_I, OPTIMIZER_APPLIED_LIMIT_I,
                   BUCK_OUTPUT_FAULT_I, SAFETY_TIMER_EXPIRED_STATE_I, BATTERY_OVERVOLTAGE_STATE_I,
                   DIE_SHUTDOWN_STATE_I, INPUT_OVERVOLTAGE_STATE_I, THERMISTOR_ZONE_I,
                   MIN_SYSTEM_REGULATING_I, OPTIMIZER_STATE_I, INPUT_SOURCE_TYPE_I, SOURCE_GOOD_STATE_I,
                   CHARGE_PHASE_I, WATCHDOG_EXPIRED_STATE_I, THERMAL_LOOP_ACTIVE_I,
                   INPUT_VOLTAGE_LOOP_ACTIVE_I, INPUT_CURRENT_LOOP_ACTIVE_I};

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      // Bus lines reset to their idle high level, so no false edge after reset
      sync_a <= `CSFM_SYNC_IDLE;
      sync_b <= `CSFM_SYNC_IDLE;
      sync_c <= `CSFM_SYNC_IDLE;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // ***************************************************
  // Live status images
  // ***************************************************
  wire [7:0] stat_one_now;
  wire [7:0] stat_one_old;
  wire [7:0] stat_two_now;
  wire [7:0] stat_two_old;
  wire [7:0] therm_now;
  wire [7:0] therm_old;
  wire [7:0] fault_now;
  wire [7:0] fault_old;
  wire [7:0] limit_now;

  assign stat_one_now = {1'b0, sync_b[`CSFM_SY_LOOPS_LSB], sync_b[`CSFM_SY_LOOPS_LSB+1],
                         sync_b[`CSFM_SY_LOOPS_LSB+2], sync_b[`CSFM_SY_LOOPS_MSB],
                         sync_b[`CSFM_SY_PHASE_MSB:`CSFM_SY_PHASE_LSB]};
  assign stat_one_old = {1'b0, sync_c[`CSFM_SY_LOOPS_LSB], sync_c[`CSFM_SY_LOOPS_LSB+1],
                         sync_c[`CSFM_SY_LOOPS_LSB+2], sync_c[`CSFM_SY_LOOPS_MSB],
                         sync_c[`CSFM_SY_PHASE_MSB:`CSFM_SY_PHASE_LSB]};
  assign stat_two_now = {sync_b[`CSFM_SY_GOOD], sync_b[`CSFM_SY_SRC_MSB:`CSFM_SY_SRC_LSB], 1'b0,
                         sync_b[`CSFM_SY_OPT_MSB:`CSFM_SY_OPT_LSB], sync_b[`CSFM_SY_MINSYS]};
  assign stat_two_old = {sync_c[`CSFM_SY_GOOD], sync_c[`CSFM_SY_SRC_MSB:`CSFM_SY_SRC_LSB], 1'b0,
                         sync_c[`CSFM_SY_OPT_MSB:`CSFM_SY_OPT_LSB], sync_c[`CSFM_SY_MINSYS]};
  assign therm_now = {5'h00, sync_b[`CSFM_SY_TS_MSB:`CSFM_SY_TS_LSB]};
  assign therm_old = {5'h00, sync_c[`CSFM_SY_TS_MSB:`CSFM_SY_TS_LSB]};
  assign fault_now = {sync_b[`CSFM_SY_FAULT_LSB], sync_b[`CSFM_SY_FAULT_LSB+1], sync_b[`CSFM_SY_FAULT_LSB+2],
                      sync_b[`CSFM_SY_FAULT_MSB], 4'h0};
  assign fault_old = {sync_c[`CSFM_SY_FAULT_LSB], sync_c[`CSFM_SY_FAULT_LSB+1], sync_c[`CSFM_SY_FAULT_LSB+2],
                      sync_c[`CSFM_SY_FAULT_MSB], 4'h0};
  assign limit_now = {3'h0, sync_b[`CSFM_SY_LIMIT_MSB:`CSFM_SY_LIMIT_LSB]};

  // ***************************************************
  // Event detection
  // ***************************************************
  wire [7:0] set_one;
  wire [7:0] set_two;
  wire [7:0] set_fault;
  wire adc_done_rise;

  assign set_one = {1'b0, stat_one_now[6:3] & ~stat_one_old[6:3], 2'h0,
                    stat_one_now[2:0] != stat_one_old[2:0]};
  assign set_two = {stat_two_now[7] ^ stat_two_old[7], 2'h0,
                    stat_two_now[6:4] != stat_two_old[6:4], 1'b0,
                    therm_now[2:0] != therm_old[2:0],
                    stat_two_now[2:1] != stat_two_old[2:1],
                    stat_two_now[0] ^ stat_two_old[0]};
  assign set_fault = {fault_now[7:4] & ~fault_old[7:4], 3'h0,
                      sync_b[`CSFM_SY_BUCK_FAULT] & ~sync_c[`CSFM_SY_BUCK_FAULT]};
  assign adc_done_rise = sync_b[`CSFM_SY_ADC_DONE] & ~sync_c[`CSFM_SY_ADC_DONE];

  // ***************************************************
  // Serial register port
  // ***************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_PTR = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_RDATA = 3'd4;
  localparam [2:0] ST_ACK = 3'd5;
  localparam [2:0] ST_MACK = 3'd6;

  reg [2:0] state;
  reg [2:0] after_ack;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg [7:0] ptr;
  reg sda_drive;
  reg wr_en;
  reg rd_load;
  reg [7:0] rd_data;
  reg [7:0] buck_cfg;
  reg [7:0] mask_one;
  reg [7:0] mask_two;
  reg [7:0] fault_mask;
  reg [7:0] flags_one;
  reg [7:0] flags_two;
  reg [7:0] fault_flags;

  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;

  assign scl_rise = sync_b[`CSFM_SY_SCL] & ~sync_c[`CSFM_SY_SCL];
  assign scl_fall = ~sync_b[`CSFM_SY_SCL] & sync_c[`CSFM_SY_SCL];
  assign bus_start = sync_b[`CSFM_SY_SCL] & sync_c[`CSFM_SY_SCL] & ~sync_b[`CSFM_SY_SDA] & sync_c[`CSFM_SY_SDA];
  assign bus_stop = sync_b[`CSFM_SY_SCL] & sync_c[`CSFM_SY_SCL] & sync_b[`CSFM_SY_SDA] & ~sync_c[`CSFM_SY_SDA];
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_drive;

  // Read mux; unmapped offsets read zero
  always @*
  begin
    case (ptr)
      `CSFM_OFS_BUCK_CFG: rd_data = buck_cfg;
      `CSFM_OFS_OPT_LIMIT: rd_data = limit_now;
      `CSFM_OFS_STATUS_ONE: rd_data = stat_one_now;
      `CSFM_OFS_STATUS_TWO: rd_data = stat_two_now;
      `CSFM_OFS_THERM_STATUS: rd_data = therm_now;
      `CSFM_OFS_FAULT_STATUS: rd_data = fault_now;
      `CSFM_OFS_FLAGS_ONE: rd_data = flags_one;
      `CSFM_OFS_FLAGS_TWO: rd_data = flags_two;
      `CSFM_OFS_FAULT_FLAGS: rd_data = fault_flags;
      `CSFM_OFS_MASK_ONE: rd_data = mask_one;
      `CSFM_OFS_MASK_TWO: rd_data = mask_two;
      `CSFM_OFS_FAULT_MASK: rd_data = fault_mask;
      default: rd_data = `CSFM_RST_ZERO;
    endcase
  end

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      sda_drive <= 1'b0;
      wr_en <= 1'b0;
      rd_load <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      rd_load <= 1'b0;
      if (bus_start)
      begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_drive <= 1'b0;
      end
      else if (bus_stop)
      begin
        state <= ST_IDLE;
        sda_drive <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA:
          begin
            if (scl_rise && bit_cnt != 4'h8)
            begin
              shift <= {shift[6:0], sync_b[`CSFM_SY_SDA]};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR)
              begin
                if (shift[7:1] == DEV_ADDR)
                begin
                  sda_drive <= 1'b1;
                  state <= ST_ACK;
                  after_ack <= shift[0] ? ST_RDATA : ST_PTR;
                end
                else
                begin
                  state <= ST_IDLE;
                end
              end
              else
              begin
                if (state == ST_PTR)
                begin
                  ptr <= shift;
                end
                else
                begin
                  wr_en <= 1'b1;
                end
                sda_drive <= 1'b1;
                state <= ST_ACK;
                after_ack <= ST_WDATA;
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              state <= after_ack;
              sda_drive <= 1'b0;
              if (after_ack == ST_RDATA)
              begin
                // Byte is latched here, so the flag clear never races the shift
                rd_load <= 1'b1;
                sda_drive <= ~rd_data[7];
                tx <= {rd_data[6:0], 1'b0};
                bit_cnt <= 4'h1;
              end
            end
          end
          ST_RDATA:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == 4'h8)
              begin
                sda_drive <= 1'b0;
                state <= ST_MACK;
              end
              else
              begin
                sda_drive <= ~tx[7];
                tx <= {tx[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_MACK:
          begin
            if (scl_rise)
            begin
              state <= sync_b[`CSFM_SY_SDA] ? ST_IDLE : ST_ACK;
              after_ack <= ST_RDATA;
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
        if (wr_en || rd_load)
        begin
          ptr <= ptr + 8'h01;
        end
      end
    end
  end

  // ***************************************************
  // Writable registers
  // ***************************************************
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      buck_cfg <= `CSFM_RST_BUCK_CFG;
      mask_one <= `CSFM_RST_ZERO;
      mask_two <= `CSFM_RST_ZERO;
      fault_mask <= `CSFM_RST_ZERO;
    end
    else if (wr_en)
    begin
      case (ptr)
        `CSFM_OFS_BUCK_CFG: buck_cfg <= shift & `CSFM_WMASK_BUCK_CFG;
        `CSFM_OFS_MASK_ONE: mask_one <= shift & `CSFM_WMASK_MASK_ONE;
        `CSFM_OFS_MASK_TWO: mask_two <= shift & `CSFM_WMASK_MASK_TWO;
        `CSFM_OFS_FAULT_MASK: fault_mask <= shift & `CSFM_WMASK_FAULT_MASK;
        default: buck_cfg <= buck_cfg;
      endcase
    end
  end

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      BUCK_OUTPUT_VOLTAGE_SETTING_O <= 4'h0;
    end
    else if (buck_cfg[`CSFM_BUCK_VOLT_MSB:0] > `CSFM_BUCK_VOLT_MAX)
    begin
      BUCK_OUTPUT_VOLTAGE_SETTING_O <= `CSFM_BUCK_VOLT_MAX;
    end
    else
    begin
      BUCK_OUTPUT_VOLTAGE_SETTING_O <= buck_cfg[`CSFM_BUCK_VOLT_MSB:0];
    end
  end

  // ***************************************************
  // Sticky flags
  // ***************************************************
  wire clr_one;
  wire clr_two;
  wire clr_fault;

  assign clr_one = rd_load && ptr == `CSFM_OFS_FLAGS_ONE;
  assign clr_two = rd_load && ptr == `CSFM_OFS_FLAGS_TWO;
  assign clr_fault = rd_load && ptr == `CSFM_OFS_FAULT_FLAGS;

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      flags_one <= `CSFM_RST_ZERO;
      flags_two <= `CSFM_RST_ZERO;
      fault_flags <= `CSFM_RST_ZERO;
    end
    else
    begin
      // A new event in the clearing cycle survives
      flags_one <= (flags_one & ~{8{clr_one}}) | set_one;
      flags_two <= (flags_two & ~{8{clr_two}}) | set_two;
      fault_flags <= (fault_flags & ~{8{clr_fault}}) | set_fault;
    end
  end

  // ***************************************************
  // Interrupt pulse
  // ***************************************************
  // A fresh event during a pulse restarts it, so back-to-back events
  // merge into one longer pulse rather than being lost.
  wire int_fire;
  reg [15:0] int_cnt;

  assign int_fire = |(set_one & ~mask_one) | |(set_two & ~mask_two) | |(set_fault & ~fault_mask)
                    | (adc_done_rise & sync_b[`CSFM_SY_ONE_SHOT]
                       & ~mask_one[`CSFM_ADC_DONE_BLOCK_BIT]);
  assign INT_O = 1'b0;

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      int_cnt <= 16'h0000;
      INT_OE_O <= 1'b0;
    end
    else if (int_fire)
    begin
      int_cnt <= INT_PULSE_CYCLES[15:0] - 16'h0001;
      INT_OE_O <= 1'b1;
    end
    else if (int_cnt != 16'h0000)
    begin
      int_cnt <= int_cnt - 16'h0001;
    end
    else
    begin
      INT_OE_O <= 1'b0;
    end
  end

endmodule

// ==== verification/csfm_flag_bank_monitor.sv ====
`timescale 1ns/1ps
// ****
// Port checker
// ****
module csfm_flag_bank_monitor
#(
  parameter [6:0] DEV_ADDR = 7'h50,
  parameter INT_PULSE_CYCLES = 100
)
(
  input wire CLK_I,
  input wire RST_I,
  input wire SCL_I,
  input wire SDA_O,
  input wire SDA_OE_O,
  input wire INT_O,
  input wire INT_OE_O,
  input wire INPUT_CURRENT_LOOP_ACTIVE_I,
  input wire INPUT_VOLTAGE_LOOP_ACTIVE_I,
  input wire THERMAL_LOOP_ACTIVE_I,
  input wire WATCHDOG_EXPIRED_STATE_I,
  input wire [2:0] CHARGE_PHASE_I,
  input wire SOURCE_GOOD_STATE_I,
  input wire [2:0] INPUT_SOURCE_TYPE_I,
  input wire [1:0] OPTIMIZER_STATE_I,
  input wire MIN_SYSTEM_REGULATING_I,
  input wire [2:0] THERMISTOR_ZONE_I,
  input wire INPUT_OVERVOLTAGE_STATE_I,
  input wire DIE_SHUTDOWN_STATE_I,
  input wire BATTERY_OVERVOLTAGE_STATE_I,
  input wire SAFETY_TIMER_EXPIRED_STATE_I,
  input wire BUCK_OUTPUT_FAULT_I,
  input wire CONVERSION_DONE_I,
  input wire CONVERSION_ONE_SHOT_I,
  input wire [3:0] BUCK_OUTPUT_VOLTAGE_SETTING_O
);
  wire [21:0] st = {INPUT_CURRENT_LOOP_ACTIVE_I, INPUT_VOLTAGE_LOOP_ACTIVE_I, THERMAL_LOOP_ACTIVE_I,
    WATCHDOG_EXPIRED_STATE_I, CHARGE_PHASE_I, SOURCE_GOOD_STATE_I, INPUT_SOURCE_TYPE_I, OPTIMIZER_STATE_I,
    MIN_SYSTEM_REGULATING_I, THERMISTOR_ZONE_I, INPUT_OVERVOLTAGE_STATE_I, DIE_SHUTDOWN_STATE_I,
    BATTERY_OVERVOLTAGE_STATE_I, SAFETY_TIMER_EXPIRED_STATE_I, BUCK_OUTPUT_FAULT_I};
  reg [21:0] st_q;
  reg conv_q;
  reg [5:0] hist;
  // Lenient: any status pin change, or a one-shot conversion rise, counts as a possible cause
  always @(posedge CLK_I)
  begin
    st_q <= st;
    conv_q <= CONVERSION_DONE_I;
    hist <= {hist[4:0], (st != st_q) | (CONVERSION_DONE_I & !conv_q & CONVERSION_ONE_SHOT_I)};
  end
  a_buck_clamp: assert property (@(posedge CLK_I) disable iff (RST_I)
    BUCK_OUTPUT_VOLTAGE_SETTING_O <= 4'hA) else $error("buck setting above clamp");
  a_buck_reset_value: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(RST_I) |-> ##[0:3] BUCK_OUTPUT_VOLTAGE_SETTING_O == 4'h6) else $error("buck reset value");
  a_reset_quiet: assert property (@(posedge CLK_I) RST_I |=>
    (!INT_OE_O && !SDA_OE_O && BUCK_OUTPUT_VOLTAGE_SETTING_O == 4'h0)) else $error("outputs busy in reset");
  a_open_drain_low: assert property (@(posedge CLK_I) disable iff (RST_I)
    !INT_O && !SDA_O) else $error("open drain level not low");
  a_int_pulse_width: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(INT_OE_O) |-> INT_OE_O[*4]) else $error("interrupt pulse too short");
  a_int_has_cause: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(INT_OE_O) |-> (|hist)) else $error("interrupt without event");
  a_sda_scl_low: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(SDA_OE_O) |-> !SCL_I) else $error("data moved while clock high");
  a_ack_stands: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(SDA_OE_O) |-> SDA_OE_O[*5]) else $error("data low too short");
endmodule
bind csfm_flag_bank csfm_flag_bank_monitor #(.DEV_ADDR(DEV_ADDR), .INT_PULSE_CYCLES(INT_PULSE_CYCLES)) u_mon (.*);

// ==== verification/csfm_host_model.sv ====
`timescale 1ns/1ps
// ****
// Host on the register bus
// ****
module csfm_host_model
#(
  parameter [6:0] DEV_ADDR = 7'h50
)
(
  input wire clk_i,
  input wire sda_i,
  output reg scl_low_o,
  output reg sda_low_o
);
  integer nacks;
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    nacks = 0;
  end
  task hp(input integer n);
  begin
    repeat (n) @(negedge clk_i);
  end
  endtask
  // Also a repeated start, as the clock is left low
  task start;
  begin
    sda_low_o = 1'b0;
    hp(3);
    scl_low_o = 1'b0;
    hp(6);
    sda_low_o = 1'b1;
    hp(6);
    scl_low_o = 1'b1;
    hp(3);
  end
  endtask
  task stop;
  begin
    sda_low_o = 1'b1;
    hp(3);
    scl_low_o = 1'b0;
    hp(6);
    sda_low_o = 1'b0;
    hp(6);
  end
  endtask
  task xbit(input b, output r);
  begin
    sda_low_o = !b;
    hp(3);
    scl_low_o = 1'b0;
    hp(3);
    r = sda_i;
    hp(3);
    scl_low_o = 1'b1;
    hp(3);
  end
  endtask
  // Single-byte reads end with a release, so no acknowledge
  task xbyte(input [7:0] d, input w, output [7:0] q);
    integer i;
    reg a;
  begin
    for (i = 7; i >= 0; i = i - 1)
      xbit(d[i], q[i]);
    xbit(1'b1, a);
    if (w && a)
      nacks = nacks + 1;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg [7:0] q;
  begin
    start;
    xbyte({DEV_ADDR, 1'b0}, 1'b1, q);
    xbyte(a, 1'b1, q);
    xbyte(d, 1'b1, q);
    stop;
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    start;
    xbyte({DEV_ADDR, 1'b0}, 1'b1, d);
    xbyte(a, 1'b1, d);
    start;
    xbyte({DEV_ADDR, 1'b1}, 1'b1, d);
    xbyte(8'hFF, 1'b0, d);
    stop;
  end
  endtask
  task probe(input [6:0] a);
    reg [7:0] q;
  begin
    start;
    xbyte({a, 1'b0}, 1'b1, q);
    stop;
  end
  endtask
endmodule

// ==== verification/charger_status_flag_mask_bank_tb_top.sv ====
`timescale 1ns/1ps
module charger_status_flag_mask_bank_tb_top;
  reg clk;
  reg rst;
  reg [28:0] v;
  reg [28:0] o;
  reg [31:0] seed;
  reg [7:0] d;
  reg [39:0] e;
  reg hit;
  integer fail_count;
  integer checked;
  integer cyc = 0;
  integer i;
  integer k;
  wire scl_low;
  wire sda_low;
  wire sda_oe;
  wire int_oe;
  wire [3:0] buck;
  wire sda_w = !(sda_oe | sda_low);
  csfm_flag_bank #(.INT_PULSE_CYCLES(4)) u_dut (.CLK_I(clk), .RST_I(rst), .SCL_I(!scl_low), .SDA_I(sda_w),
    .SDA_O(), .SDA_OE_O(sda_oe), .INT_O(), .INT_OE_O(int_oe), .INPUT_CURRENT_LOOP_ACTIVE_I(v[0]),
    .INPUT_VOLTAGE_LOOP_ACTIVE_I(v[1]), .THERMAL_LOOP_ACTIVE_I(v[2]), .WATCHDOG_EXPIRED_STATE_I(v[3]),
    .CHARGE_PHASE_I(v[6:4]), .SOURCE_GOOD_STATE_I(v[7]), .INPUT_SOURCE_TYPE_I(v[10:8]),
    .OPTIMIZER_STATE_I(v[12:11]), .MIN_SYSTEM_REGULATING_I(v[13]), .THERMISTOR_ZONE_I(v[16:14]),
    .INPUT_OVERVOLTAGE_STATE_I(v[17]), .DIE_SHUTDOWN_STATE_I(v[18]), .BATTERY_OVERVOLTAGE_STATE_I(v[19]),
    .SAFETY_TIMER_EXPIRED_STATE_I(v[20]), .BUCK_OUTPUT_FAULT_I(v[21]), .OPTIMIZER_APPLIED_LIMIT_I(v[26:22]),
    .CONVERSION_DONE_I(v[27]), .CONVERSION_ONE_SHOT_I(v[28]), .BUCK_OUTPUT_VOLTAGE_SETTING_O(buck));
  csfm_host_model u_host (.clk_i(clk), .sda_i(sda_w), .scl_low_o(scl_low), .sda_low_o(sda_low));
  // ****
  // Expectations
  // ****
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
  begin
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  end
  endfunction
  function [39:0] stx(input [28:0] x);
    stx = {3'b0, x[26:22], 1'b0, x[0], x[1], x[2], x[3], x[6:4], x[7], x[10:8], 1'b0, x[12:11], x[13],
      5'b0, x[16:14], x[17], x[18], x[19], x[20], 4'b0};
  endfunction
  function [23:0] flx(input [28:0] a, input [28:0] b);
    reg [28:0] r;
    reg [28:0] c;
  begin
    r = b & ~a;
    c = b ^ a;
    flx = {1'b0, r[0], r[1], r[2], r[3], 2'b0, |c[6:4], c[7], 2'b0, |c[10:8], 1'b0, |c[16:14], |c[12:11],
      c[13], r[17], r[18], r[19], r[20], 3'b0, r[21]};
  end
  endfunction
  // ****
  // Checks and steps
  // ****
  task chk(input [63:0] nm, input [7:0] a, input [7:0] x, input [7:0] g);
  begin
    checked = checked + 1;
    if (g !== x)
    begin
      fail_count = fail_count + 1;
      $display("wrong value %0s %h expected %h seen %h", nm, a, x, g);
    end
  end
  endtask
  task rdc(input [7:0] a, input [7:0] x);
  begin
    u_host.rd(a, d);
    chk("reg", a, x, d);
  end
  endtask
  task watch(input x);
    integer j;
  begin
    hit = 1'b0;
    for (j = 0; j < 12; j = j + 1)
    begin
      @(posedge clk);
      #1;
      if (int_oe === 1'b1)
        hit = 1'b1;
    end
    chk("int", 8'h00, {7'h0, x}, {7'h0, hit});
  end
  endtask
  task step(input [28:0] n, input m);
  begin
    o = v;
    @(negedge clk);
    v = n;
    watch(!m && (|flx(o, n)));
    e = stx(v);
    for (k = 0; k < 5; k = k + 1)
      rdc(8'h0A + k[7:0], e[39-8*k -: 8]);
    e = {16'h0, flx(o, n)};
    for (k = 0; k < 3; k = k + 1)
      rdc(8'h0F + k[7:0], e[23-8*k -: 8]);
    for (k = 0; k < 3; k = k + 1)
      rdc(8'h0F + k[7:0], 8'h00);
  end
  endtask
  task conv(input os, input x);
  begin
    @(negedge clk);
    v[28] = os;
    v[27] = 1'b1;
    watch(x);
    v[27] = 1'b0;
    repeat (4) @(negedge clk);
  end
  endtask
  task summarize;
  begin
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole plan needs about 70000 cycles
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      fail_count = fail_count + 1;
      summarize;
    end
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    rst = 1'b1;
    v = 29'h0;
    seed = 32'd94;
    fail_count = 0;
    checked = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("buck", 8'h09, 8'h06, {4'h0, buck});
    rdc(8'h09, 8'hF6);
    for (k = 0; k < 6; k = k + 1)
      rdc(8'h0F + k[7:0], 8'h00);
    step(29'h07FFFFFF, 1'b0);
    step(29'h0, 1'b0);
    for (i = 0; i < 5; i = i + 1)
    begin
      seed = xs(seed);
      step(v ^ seed[28:0] & 29'h07FFFFFF, 1'b0);
    end
    for (k = 0; k < 3; k = k + 1)
      u_host.wr(8'h12 + k[7:0], 8'hFF);
    rdc(8'h12, 8'hF9);
    rdc(8'h13, 8'h97);
    rdc(8'h14, 8'hF9);
    for (i = 0; i < 2; i = i + 1)
    begin
      seed = xs(seed);
      step(v ^ seed[28:0] & 29'h07FFFFFF, 1'b1);
    end
    u_host.wr(8'h12, 8'h79);
    conv(1'b0, 1'b0);
    conv(1'b1, 1'b1);
    u_host.wr(8'h12, 8'hFF);
    conv(1'b1, 1'b0);
    for (k = 0; k < 16; k = k + 1)
    begin
      u_host.wr(8'h09, {~k[3:0], k[3:0]});
      rdc(8'h09, {~k[3:0], k[3:0]});
      chk("buck", 8'h09, (k > 10) ? 8'h0A : k[7:0], {4'h0, buck});
    end
    rdc(8'h20, 8'h00);
    u_host.wr(8'h0F, 8'hFF);
    rdc(8'h0F, 8'h00);
    u_host.wr(8'h0B, 8'h00);
    e = stx(v);
    rdc(8'h0B, e[31:24]);
    u_host.probe(7'h51);
    chk("nacks", 8'h00, 8'h01, u_host.nacks[7:0]);
    summarize;
  end
endmodule
